// ### rtl/asr_params.svh
// Constants for the ASCII string receiver and search unit.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

`define ASR_CLK_NS      25
`define ASR_MS_NS       1000000
`define ASR_MEM_WORDS   128
`define ASR_STG_BYTES   130
`define ASR_PAT_CHARS   128
`define ASR_BUF_DEPTH   2
`define ASR_NOT_FOUND   16'hffff

`endif

// ### rtl/asr_pkg.sv
// Types shared by the receiver, its buffer and the byte link interface.
// Assumes asr_params.svh is on the include path.
package asr_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] word_t;
    typedef logic [6:0]  waddr_t;
    typedef enum logic [2:0] {RX_WAIT_LOW, RX_IDLE, RX_RECV, RX_COMMIT, RX_DONE} rx_state_e;
    typedef enum logic [1:0] {S_IDLE, S_CMP, S_WR} search_state_e;
endpackage

// ### rtl/byte_link_if.sv
// Valid/ready byte link between the receiver and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface byte_link_if;
    import asr_pkg::*;
    logic  valid;
    logic  ready;
    byte_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/byte_skid_buffer.sv
// Two-entry byte buffer with valid and ready on both sides.
// Assumes a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "asr_params.svh"
module byte_skid_buffer (
    input  wire logic   clk,
    input  wire logic   rst_b,
    byte_link_if.snk    fill,
    byte_link_if.src    drain
);
    import asr_pkg::*;
    byte_t      slot [0:`ASR_BUF_DEPTH-1];
    logic       wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0] level, next_level;
    logic       push, pop;

    // Full and empty come straight from the fill level
    assign fill.ready  = (level != 2'(`ASR_BUF_DEPTH));
    assign drain.valid = (level != 2'h0);
    assign drain.data  = slot[rd_ptr];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    // Pointer and level update
    always_comb begin
        next_wr_ptr = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
        next_level  = level + 2'(push) - 2'(pop);
    end

    // Register pointers and slots
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            level  <= 2'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level  <= next_level;
            if (push) begin
                slot[wr_ptr] <= fill.data;
            end
        end
    end
endmodule // byte_skid_buffer
`default_nettype wire

// ### rtl/ascii_string_receiver_finder.sv
// ASCII string receiver (ascii_input_op) with word store and substring search
// (ascii_search_op). Assumes one 40 MHz clock and a serial source that already
// delivers whole characters as valid/ready bytes synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "asr_params.svh"
module ascii_string_receiver_finder #(
    parameter int unsigned MS_CYCLES = `ASR_MS_NS / `ASR_CLK_NS
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            rx_valid,
    input  wire asr_pkg::byte_t  rx_data,
    output logic                 rx_ready,
    input  wire logic            permit,
    input  wire logic            variable_len,
    input  wire logic [7:0]      fixed_len,
    input  wire logic [7:0]      max_len,
    input  wire logic            term_two,
    input  wire asr_pkg::byte_t  term_char0,
    input  wire asr_pkg::byte_t  term_char1,
    input  wire logic [7:0]      ic_timeout_ms,
    input  wire logic [7:0]      fc_timeout_ms,
    input  wire logic            word_byte_exchange_op,
    input  wire asr_pkg::waddr_t dest_base,
    output logic                 busy,
    output logic                 complete,
    output logic                 ic_timeout_err,
    output logic                 fc_timeout_err,
    output logic                 overflow_err,
    output logic [7:0]           rx_count,
    input  wire logic            search_go,
    input  wire asr_pkg::waddr_t search_base,
    input  wire logic [7:0]      search_total,
    input  wire logic [6:0]      search_skip,
    input  wire logic            search_reverse,
    input  wire logic            search_report_end,
    input  wire asr_pkg::waddr_t search_result_addr,
    input  wire logic [7:0]      pat_len,
    input  wire logic            pat_wr,
    input  wire logic [6:0]      pat_addr,
    input  wire asr_pkg::byte_t  pat_data,
    output logic                 search_busy,
    output logic                 search_done,
    output asr_pkg::word_t       found_index,
    input  wire asr_pkg::waddr_t rd_addr,
    output asr_pkg::word_t       rd_data
);
    import asr_pkg::*;

    byte_link_if in_link ();
    byte_link_if out_link ();

    byte_t         stg [0:`ASR_STG_BYTES-1];
    word_t         mem [0:`ASR_MEM_WORDS-1];
    byte_t         pat [0:`ASR_PAT_CHARS-1];
    rx_state_e     rst_st, next_rst_st;
    search_state_e sst, next_sst;
    logic          next_busy, next_complete, next_ic, next_fc, next_ovf;
    logic [7:0]    count, next_count;
    logic [6:0]    wr_idx, next_wr_idx;
    byte_t         prev, next_prev;
    logic          got_first, next_got_first;
    logic [15:0]   ms_div, next_ms_div;
    logic [8:0]    ms_count, next_ms_count;
    logic          ms_tick, take, term_hit;
    logic          stg_we, mem_we;
    waddr_t        mem_waddr;
    word_t         mem_wdata;
    logic [7:0]    cand, next_cand, k, next_k, last_cand;
    word_t         result, next_result;
    logic          next_done;
    byte_t         mem_byte;
    byte_t         lo_b, hi_b;

    // Pick one byte of a word; even byte addresses are the low byte
    function automatic byte_t pick_byte(input word_t w, input logic hi);
        pick_byte = hi ? w[15:8] : w[7:0];
    endfunction

    // Input side goes through the two-entry buffer
    assign in_link.valid = rx_valid;
    assign in_link.data  = rx_data;
    assign rx_ready      = in_link.ready;
    byte_skid_buffer u_buf (
        .clk   (clk),
        .rst_b (rst_b),
        .fill  (in_link.snk),
        .drain (out_link.src)
    );
    // Receiver stalls the buffer while a search owns the store
    assign out_link.ready = (rst_st == RX_RECV) && (sst == S_IDLE);
    assign take           = out_link.valid && out_link.ready;

    // Millisecond tick and terminator detection
    assign ms_tick  = (ms_div == 16'(MS_CYCLES - 1));
    assign term_hit = term_two ? (out_link.data == term_char1 && got_first &&
                                  prev == term_char0)
                               : (out_link.data == term_char0);
    assign lo_b     = stg[{wr_idx, 1'b0}];
    assign hi_b     = ({wr_idx, 1'b1} < count) ? stg[{wr_idx, 1'b1}] : 8'h00;
    assign mem_byte = pick_byte(mem[7'(({search_base, 1'b0} + cand + k) >> 1)],
                                cand[0] ^ k[0]);
    assign last_cand = search_total - pat_len;

    // Receiver next state
    always_comb begin
        next_rst_st    = rst_st;
        next_busy      = busy;
        next_complete  = complete;
        next_ic        = ic_timeout_err;
        next_fc        = fc_timeout_err;
        next_ovf       = overflow_err;
        next_count     = count;
        next_wr_idx    = wr_idx;
        next_prev      = prev;
        next_got_first = got_first;
        next_ms_div    = ms_tick ? 16'h0000 : ms_div + 16'h0001;
        next_ms_count  = (ms_tick && ms_count != 9'h1ff) ? ms_count + 9'h001 : ms_count;
        stg_we         = 1'b0;
        unique case (rst_st)
            RX_WAIT_LOW, RX_DONE: begin
                if (!permit) begin
                    next_rst_st   = RX_IDLE;
                    next_complete = 1'b0;
                    next_ic       = 1'b0;
                    next_fc       = 1'b0;
                    next_ovf      = 1'b0;
                end
            end
            RX_IDLE: begin
                if (permit) begin
                    next_rst_st    = RX_RECV;
                    next_busy      = 1'b1;
                    next_count     = 8'h00;
                    next_got_first = 1'b0;
                    next_ms_div    = 16'h0000;
                    next_ms_count  = 9'h000;
                end
            end
            RX_RECV: begin
                if (!permit) begin
                    next_rst_st = RX_IDLE;
                    next_busy   = 1'b0;
                end else if (take) begin
                    next_ms_div    = 16'h0000;
                    next_ms_count  = 9'h000;
                    next_prev      = out_link.data;
                    next_got_first = 1'b1;
                    if (variable_len && !term_hit && count >= max_len &&
                        !(term_two && out_link.data == term_char0 && count == max_len)) begin
                        next_ovf    = 1'b1;
                        next_busy   = 1'b0;
                        next_rst_st = RX_DONE;
                    end else begin
                        stg_we      = 1'b1;
                        next_count  = count + 8'h01;
                        next_wr_idx = 7'h00;
                        if (variable_len ? term_hit : (count + 8'h01 >= fixed_len)) begin
                            next_rst_st = RX_COMMIT;
                        end
                    end
                end else if (got_first && ic_timeout_ms != 8'h00 &&
                             ms_count > {1'b0, ic_timeout_ms}) begin
                    next_ic     = 1'b1;
                    next_busy   = 1'b0;
                    next_rst_st = RX_DONE;
                end else if (!got_first && fc_timeout_ms != 8'h00 &&
                             ms_count > {1'b0, fc_timeout_ms}) begin
                    next_fc     = 1'b1;
                    next_busy   = 1'b0;
                    next_rst_st = RX_DONE;
                end
            end
            RX_COMMIT: begin
                next_wr_idx = wr_idx + 7'h01;
                // Permit lost while storing aborts like a cut reception
                if (!permit) begin
                    next_rst_st = RX_IDLE;
                    next_busy   = 1'b0;
                end else if ({1'b0, wr_idx, 1'b0} + 9'h002 >= {1'b0, count}) begin
                    next_complete = 1'b1;
                    next_busy     = 1'b0;
                    next_rst_st   = RX_DONE;
                end
            end
            default: next_rst_st = RX_WAIT_LOW;
        endcase
    end

    // Search next state; compares one byte per cycle
    always_comb begin
        next_sst    = sst;
        next_cand   = cand;
        next_k      = k;
        next_result = result;
        next_done   = 1'b0;
        unique case (sst)
            S_IDLE: begin
                if (search_go) begin
                    next_k = 8'h00;
                    next_cand = search_reverse ? last_cand : {1'b0, search_skip};
                    if (pat_len == 8'h00 || pat_len > `ASR_PAT_CHARS ||
                        pat_len > search_total ||
                        {1'b0, search_skip} > last_cand) begin
                        next_result = `ASR_NOT_FOUND;
                        next_sst    = S_WR;
                    end else begin
                        next_sst = S_CMP;
                    end
                end
            end
            S_CMP: begin
                if (mem_byte == pat[k[6:0]]) begin
                    if (k == pat_len - 8'h01) begin
                        next_result = {8'h00, search_report_end ? cand + k : cand};
                        next_sst    = S_WR;
                    end else begin
                        next_k = k + 8'h01;
                    end
                end else begin
                    next_k = 8'h00;
                    if (search_reverse ? (cand == {1'b0, search_skip}) : (cand == last_cand)) begin
                        next_result = `ASR_NOT_FOUND;
                        next_sst    = S_WR;
                    end else begin
                        next_cand = search_reverse ? cand - 8'h01 : cand + 8'h01;
                    end
                end
            end
            S_WR: begin
                if (rst_st != RX_COMMIT) begin
                    next_done = 1'b1;
                    next_sst  = S_IDLE;
                end
            end
            default: next_sst = S_IDLE;
        endcase
    end

    // Store write port: the receiver's commit wins over the search result
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = search_result_addr;
        mem_wdata = result;
        if (rst_st == RX_COMMIT) begin
            mem_we    = 1'b1;
            mem_waddr = dest_base + wr_idx;
            mem_wdata = word_byte_exchange_op ? {lo_b, hi_b} : {hi_b, lo_b};
        end else if (sst == S_WR) begin
            mem_we = 1'b1;
        end
    end

    // Register all state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rst_st         <= RX_WAIT_LOW;
            sst            <= S_IDLE;
            busy           <= 1'b0;
            complete       <= 1'b0;
            ic_timeout_err <= 1'b0;
            fc_timeout_err <= 1'b0;
            overflow_err   <= 1'b0;
            count          <= 8'h00;
            wr_idx         <= 7'h00;
            prev           <= 8'h00;
            got_first      <= 1'b0;
            ms_div         <= 16'h0000;
            ms_count       <= 9'h000;
            cand           <= 8'h00;
            k              <= 8'h00;
            result         <= 16'h0000;
            search_done    <= 1'b0;
            found_index    <= 16'h0000;
            rd_data        <= 16'h0000;
        end else begin
            rst_st         <= next_rst_st;
            sst            <= next_sst;
            busy           <= next_busy;
            complete       <= next_complete;
            ic_timeout_err <= next_ic;
            fc_timeout_err <= next_fc;
            overflow_err   <= next_ovf;
            count          <= next_count;
            wr_idx         <= next_wr_idx;
            prev           <= next_prev;
            got_first      <= next_got_first;
            ms_div         <= next_ms_div;
            ms_count       <= next_ms_count;
            cand           <= next_cand;
            k              <= next_k;
            result         <= next_result;
            search_done    <= next_done;
            rd_data        <= mem[rd_addr];
            if (next_done) begin
                found_index <= result;
            end
            if (stg_we) begin
                stg[count] <= out_link.data;
            end
            if (mem_we) begin
                mem[mem_waddr] <= mem_wdata;
            end
            if (pat_wr) begin
                pat[pat_addr] <= pat_data;
            end
        end
    end

    assign rx_count    = count;
    assign search_busy = (sst != S_IDLE);
endmodule // ascii_string_receiver_finder
`default_nettype wire

// ### dv/asr_properties.sv
// Concurrent checks on the receiver flags and the search handshake.
// Assumes the single clk domain with synchronous active-low rst_b.
`timescale 1ns/1ps
`default_nettype none
module asr_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic permit,
    input wire logic busy,
    input wire logic complete,
    input wire logic ic_timeout_err,
    input wire logic fc_timeout_err,
    input wire logic overflow_err,
    input wire logic search_go,
    input wire logic search_busy,
    input wire logic search_done
);
    logic any_err;

    // Any of the three error flags
    assign any_err = ic_timeout_err | fc_timeout_err | overflow_err;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Steps of a reception shutdown and of a search
    sequence perm_low_s; !permit; endsequence
    sequence go_taken_s; search_go && !search_busy; endsequence
    sequence search_run_s; search_busy ##[1:1000] search_done; endsequence

    chk_flags_clear: assert property (perm_low_s |=> !complete && !any_err)
        else $error("flags still set after permit low");
    chk_complete_holds: assert property (complete && permit |=> complete)
        else $error("complete dropped while permit high");
    chk_abort_idle: assert property (perm_low_s |=> !busy)
        else $error("busy while permit low");
    chk_busy_exclusive: assert property (complete || any_err |-> !busy)
        else $error("busy together with a final flag");
    chk_complete_cause: assert property ($rose(complete) |-> $past(busy))
        else $error("complete rose without a reception");
    chk_err_cause: assert property ($rose(any_err) |-> $past(busy))
        else $error("error flag rose without a reception");
    chk_search_ends: assert property (go_taken_s |=> search_run_s)
        else $error("search did not finish");
    chk_done_pulse: assert property (search_done |=> !search_done)
        else $error("search done longer than one cycle");
    chk_done_cause: assert property ($rose(search_done) |-> $past(search_busy))
        else $error("search done without a search");
endmodule // asr_properties

bind ascii_string_receiver_finder asr_properties chk_u (
    .clk(clk), .rst_b(rst_b), .permit(permit), .busy(busy), .complete(complete),
    .ic_timeout_err(ic_timeout_err), .fc_timeout_err(fc_timeout_err),
    .overflow_err(overflow_err), .search_go(search_go), .search_busy(search_busy),
    .search_done(search_done)
);
`default_nettype wire

// ### dv/ascii_source_model.sv
// Serial ASCII source, such as a scanner, offering whole characters.
// Assumes the receiver samples valid and ready on the rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module ascii_source_model (
    input  wire logic     clk,
    output logic          rx_valid,
    output asr_pkg::byte_t rx_data,
    input  wire logic     rx_ready
);
    import asr_pkg::*;

    // Line idles with no character offered
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end

    // Offer one character after a gap, hold it until taken
    task automatic send(input byte_t b, input int gap);
        repeat (gap) @(posedge clk);
        #2;
        rx_valid = 1'b1;
        rx_data  = b;
        do @(posedge clk); while (rx_ready !== 1'b1);
        #2;
        rx_valid = 1'b0;
        rx_data  = ~b; // Stale data is not left on the line
    endtask
endmodule // ascii_source_model
`default_nettype wire

// ### dv/ascii_string_receiver_finder_tb.sv
// Self-checking bench for the string receiver and search unit.
// Assumes a short millisecond (MS_CYCLES 4) and the source model on the byte side.
`timescale 1ns/1ps
`default_nettype none
module ascii_string_receiver_finder_tb;
    import asr_pkg::*;
    logic       clk, rst_b, permit, variable_len, term_two, word_byte_exchange_op;
    logic       rx_valid, rx_ready, busy, complete, ic_timeout_err, fc_timeout_err, overflow_err;
    logic       search_go, search_reverse, search_report_end, pat_wr, search_busy, search_done;
    logic [7:0] fixed_len, max_len, ic_timeout_ms, fc_timeout_ms, rx_count, search_total, pat_len;
    logic [6:0] search_skip, pat_addr;
    byte_t      rx_data, term_char0, term_char1, pat_data;
    waddr_t     dest_base, search_base, search_result_addr, rd_addr;
    word_t      found_index, rd_data;
    int         error_cnt, n_compared;

    ascii_string_receiver_finder #(.MS_CYCLES(4)) dut_u (
        .clk(clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .permit(permit), .variable_len(variable_len), .fixed_len(fixed_len), .max_len(max_len),
        .term_two(term_two), .term_char0(term_char0), .term_char1(term_char1),
        .ic_timeout_ms(ic_timeout_ms), .fc_timeout_ms(fc_timeout_ms),
        .word_byte_exchange_op(word_byte_exchange_op), .dest_base(dest_base), .busy(busy),
        .complete(complete), .ic_timeout_err(ic_timeout_err), .fc_timeout_err(fc_timeout_err),
        .overflow_err(overflow_err), .rx_count(rx_count), .search_go(search_go),
        .search_base(search_base), .search_total(search_total), .search_skip(search_skip),
        .search_reverse(search_reverse), .search_report_end(search_report_end),
        .search_result_addr(search_result_addr), .pat_len(pat_len), .pat_wr(pat_wr),
        .pat_addr(pat_addr), .pat_data(pat_data), .search_busy(search_busy),
        .search_done(search_done), .found_index(found_index), .rd_addr(rd_addr), .rd_data(rd_data)
    );
    ascii_source_model src_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic check(input string what, input word_t seen, input word_t exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Flags as {busy, complete, ic, fc, overflow}
    function automatic word_t stat();
        return {11'h000, busy, complete, ic_timeout_err, fc_timeout_err, overflow_err};
    endfunction

    task automatic rdchk(input waddr_t a, input word_t exp);
        rd_addr = a;
        cyc(1);
        check("memory word", rd_data, exp);
    endtask

    // Drop permit, see flags cleared, configure and start a reception
    task automatic arm(input logic vl, input logic [7:0] len, input logic [7:0] ic,
                       input logic [7:0] fc, input waddr_t dst);
        permit = 1'b0;
        variable_len = vl;
        fixed_len = len;
        max_len = len;
        ic_timeout_ms = ic;
        fc_timeout_ms = fc;
        dest_base = dst;
        cyc(2);
        check("flags cleared", stat(), 16'h0000);
        permit = 1'b1;
        cyc(2);
    endtask

    task automatic put(input string s, input int gap);
        foreach (s[i]) src_u.send(s[i], gap);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (busy === 1'b1 && k < 500) begin
            cyc(1);
            k++;
        end
    endtask

    // Load the pattern, run one search, check index and result word
    task automatic srch(input string p, input int skip, input int tot, input logic rv,
                        input logic en, input word_t exp);
        int k;
        foreach (p[i]) begin
            pat_wr = 1'b1;
            pat_addr = 7'(i);
            pat_data = p[i];
            cyc(1);
        end
        pat_wr = 1'b0;
        pat_len = 8'(p.len());
        search_skip = 7'(skip);
        search_total = 8'(tot);
        search_reverse = rv;
        search_report_end = en;
        search_go = 1'b1;
        cyc(1);
        search_go = 1'b0;
        k = 0;
        while (search_done !== 1'b1 && k < 5000) begin
            cyc(1);
            k++;
        end
        check("found index", found_index, exp);
        rdchk(7'h50, exp);
    endtask

    // Hang guard, well beyond the length of the sequence below
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    // Main sequence
    initial begin
        {rst_b, permit, variable_len, term_two, word_byte_exchange_op} = 5'h00;
        {search_go, search_reverse, search_report_end, pat_wr} = 4'h0;
        {fixed_len, max_len, ic_timeout_ms, fc_timeout_ms, search_total, pat_len} = '0;
        {search_skip, pat_addr, pat_data, term_char0, term_char1, dest_base, rd_addr} = '0;
        search_base = 7'h28;
        search_result_addr = 7'h50;
        error_cnt = 0;
        n_compared = 0;
        cyc(16);
        rst_b = 1'b1;
        arm(1'b0, 8'h03, 8'h00, 8'h00, 7'h0a);
        put("ABC", 0);
        wait_idle();
        check("status", stat(), 16'h0008);
        check("count", {8'h00, rx_count}, 16'h0003);
        rdchk(7'h0a, 16'h4241);
        rdchk(7'h0b, 16'h0043);
        cyc(5);
        check("status held", stat(), 16'h0008);
        word_byte_exchange_op = 1'b1;
        arm(1'b0, 8'h04, 8'h00, 8'h00, 7'h0c);
        put("WXYZ", 1);
        wait_idle();
        rdchk(7'h0c, 16'h5758);
        rdchk(7'h0d, 16'h595a);
        word_byte_exchange_op = 1'b0;
        for (int t = 0; t < 2; t++) begin
            term_two = t[0];
            term_char0 = t ? 8'h0d : 8'h3b;
            term_char1 = 8'h0a;
            arm(1'b1, 8'h08, 8'h00, 8'h00, 7'h14);
            if (t != 0) begin
                put("hi\015\n", 0);
            end else begin
                put("hi;", 0);
            end
            wait_idle();
            check("status", stat(), 16'h0008);
            rdchk(7'h14, 16'h6968);
            rdchk(7'h15, t ? 16'h0a0d : 16'h003b);
        end
        arm(1'b1, 8'h02, 8'h00, 8'h00, 7'h18);
        put("abc", 0);
        wait_idle();
        check("status", stat(), 16'h0001);
        arm(1'b0, 8'h03, 8'h02, 8'h00, 7'h0a);
        put("P", 0);
        cyc(40);
        check("status", stat(), 16'h0004);
        rdchk(7'h0a, 16'h4241);
        arm(1'b0, 8'h01, 8'h00, 8'h02, 7'h60);
        cyc(40);
        check("status", stat(), 16'h0002);
        arm(1'b0, 8'h02, 8'h00, 8'h00, 7'h62);
        cyc(40);
        put("A", 0);
        cyc(40);
        put("B", 0);
        wait_idle();
        check("status", stat(), 16'h0008);
        rdchk(7'h62, 16'h4241);
        arm(1'b0, 8'h0f, 8'h00, 8'h00, 7'h28);
        put("Today \"day\" is.", 0);
        wait_idle();
        srch("day", 0, 15, 1'b0, 1'b0, 16'h0002);
        srch("day", 3, 15, 1'b0, 1'b0, 16'h0007);
        srch("day", 3, 15, 1'b0, 1'b1, 16'h0009);
        srch("day", 0, 15, 1'b1, 1'b0, 16'h0007);
        srch("\"day\"", 0, 15, 1'b0, 1'b0, 16'h0006);
        srch("is", 0, 12, 1'b0, 1'b0, 16'hffff);
        srch("is", 0, 14, 1'b0, 1'b0, 16'h000c);
        // Permit dropped mid-string: reception stops silently
        arm(1'b0, 8'h04, 8'h00, 8'h00, 7'h70);
        put("ab", 0);
        permit = 1'b0;
        cyc(2);
        check("aborted status", stat(), 16'h0000);
        close_out();
    end
endmodule // ascii_string_receiver_finder_tb
`default_nettype wire
